// ==== hw/pia_regs_top.sv ====
`timescale 1ns/100ps
`include "pia_regs.svh"

// Contract
// - Two identifier registers form 32-bit identifier
// - Identifier may optionally read all zero
// - High identifier holds organisation ID bits 3-18
// - Top two organisation ID bits discarded
// - Low identifier 15:10 holds ID bits 19-24
// - Low identifier 9:4 holds model number
// - Low identifier 3:0 holds model revision
// - Advertisement holds local abilities sent to partner
// - Bit 15 next page, read-write, resets 0
// - Bit 14 reserved, writes ignored, reads 0
// - Bit 13 remote fault, read-write, resets 0
// - Bit 12 reserved, written 0, reads 0
// - Bit 11 asymmetric pause, read-write, resets 0
// - Bit 10 symmetric pause, read-write, resets 0
// - Pause resolution reported as control bits 13:12; the code drives it on the PAUSE_RESOLVED port instead
// - Bit 9 reads 0, read-only
// - Bits 8:6 read-write, reset from straps
// - Bit 5 strap reset; selector resets 00001
// - Status bit 5 shows negotiation complete

module pia_regs_top #(
	parameter logic [23:0] ORG_ID  = 24'h5a3c96, // Arbitrary value
	parameter logic [5:0]  MODEL   = 6'h15,      // Arbitrary value
	parameter logic [3:0]  REV     = 4'h3,       // Arbitrary value
	parameter logic        ID_ZERO = 1'b0
) (
	input  wire logic                    REF_CLK,
	input  wire logic                    RESET_N,
	input  wire pia_pkg::pia_strap_type  STRAP,
	input  wire logic [4:0]              REG_ADDR,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	input  wire logic [15:0]             REG_WDATA,
	output logic [15:0]                  REG_RDATA,
	output logic                         REG_RVALID,
	input  wire logic                    AN_COMPLETE,
	input  wire pia_pkg::pia_pause_type  PARTNER_PAUSE,
	output pia_pkg::pia_advert_type      ADVERT,
	output logic [1:0]                   PAUSE_RESOLVED
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic                    rst_meta_ff;
	logic                    rst_sync_n_ff;
	pia_pkg::pia_state_type  state_ff;
	pia_pkg::pia_state_type  nxt_state;
	pia_pkg::pia_advert_type advert_ff;
	logic [15:0]             rdata_ff;
	logic [15:0]             nxt_rdata;
	logic                    rvalid_ff;
	logic [15:0]             id_high_word;
	logic [15:0]             id_low_word;
	logic [15:0]             advert_word;
	logic [15:0]             status_word;
	logic                    adv_write;
	pia_pkg::pia_pause_type  local_pause;

	// Internal reset leaves on the second edge after RESET_N rises
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_ff   <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_meta_ff   <= 1'b1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end

	// ****************************************************************
	// Strap capture state
	// ****************************************************************
	always_comb begin
		case (state_ff)
			pia_pkg::PIA_ST_LOAD: begin
				nxt_state = pia_pkg::PIA_ST_RUN;
			end
			pia_pkg::PIA_ST_RUN: begin
				nxt_state = pia_pkg::PIA_ST_RUN;
			end
			default: begin
				nxt_state = pia_pkg::PIA_ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			state_ff <= pia_pkg::PIA_ST_LOAD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// Identifier words
	// ****************************************************************
	always_comb begin
		if (ID_ZERO) begin
			id_high_word = `PIA_RST_WORD;
			id_low_word  = `PIA_RST_WORD;
		end else begin
			id_high_word = ORG_ID[`PIA_ORG_HIGH_MSB:`PIA_ORG_HIGH_LSB];
			id_low_word  = {ORG_ID[`PIA_ORG_LOW_MSB:`PIA_ORG_LOW_LSB], MODEL, REV};
		end
	end

	// ****************************************************************
	// Advertisement register
	// ****************************************************************
	// Writes in the strap load cycle are dropped so the straps are not lost
	assign adv_write = REG_WR && (REG_ADDR == `PIA_ADDR_ADVERT) && (state_ff == pia_pkg::PIA_ST_RUN);

	always_ff @(posedge REF_CLK or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			advert_ff.next_page_request       <= `PIA_RST_BIT;
			advert_ff.remote_fault_advert     <= `PIA_RST_BIT;
			advert_ff.asymmetric_pause_advert <= `PIA_RST_BIT;
			advert_ff.pause_advert            <= `PIA_RST_BIT;
			advert_ff.fast_full_duplex_advert <= `PIA_RST_BIT;
			advert_ff.fast_half_duplex_advert <= `PIA_RST_BIT;
			advert_ff.ten_full_duplex_advert  <= `PIA_RST_BIT;
			advert_ff.ten_ability_advert      <= `PIA_RST_BIT;
			advert_ff.selector                <= `PIA_RST_SELECTOR;
		end else if (state_ff == pia_pkg::PIA_ST_LOAD) begin
			advert_ff.fast_full_duplex_advert <= STRAP.fast_full_duplex_advert;
			advert_ff.fast_half_duplex_advert <= STRAP.fast_half_duplex_advert;
			advert_ff.ten_full_duplex_advert  <= STRAP.ten_full_duplex_advert;
			advert_ff.ten_ability_advert      <= STRAP.ten_ability_advert;
		end else if (adv_write) begin
			advert_ff.next_page_request       <= REG_WDATA[`PIA_ADV_NEXT_PAGE_BIT];
			advert_ff.remote_fault_advert     <= REG_WDATA[`PIA_ADV_REMOTE_FAULT_BIT];
			advert_ff.asymmetric_pause_advert <= REG_WDATA[`PIA_ADV_ASYM_PAUSE_BIT];
			advert_ff.pause_advert            <= REG_WDATA[`PIA_ADV_PAUSE_BIT];
			advert_ff.fast_full_duplex_advert <= REG_WDATA[`PIA_ADV_FAST_FD_BIT];
			advert_ff.fast_half_duplex_advert <= REG_WDATA[`PIA_ADV_FAST_HD_BIT];
			advert_ff.ten_full_duplex_advert  <= REG_WDATA[`PIA_ADV_TEN_FD_BIT];
			advert_ff.ten_ability_advert      <= REG_WDATA[`PIA_ADV_TEN_BIT];
			advert_ff.selector                <= REG_WDATA[`PIA_ADV_SEL_MSB:`PIA_ADV_SEL_LSB];
		end
	end

	// Reserved and unsupported bits are never stored, so they read zero
	always_comb begin
		advert_word                                      = `PIA_RST_WORD;
		advert_word[`PIA_ADV_NEXT_PAGE_BIT]              = advert_ff.next_page_request;
		advert_word[`PIA_ADV_REMOTE_FAULT_BIT]           = advert_ff.remote_fault_advert;
		advert_word[`PIA_ADV_ASYM_PAUSE_BIT]             = advert_ff.asymmetric_pause_advert;
		advert_word[`PIA_ADV_PAUSE_BIT]                  = advert_ff.pause_advert;
		advert_word[`PIA_ADV_FAST_FD_BIT]                = advert_ff.fast_full_duplex_advert;
		advert_word[`PIA_ADV_FAST_HD_BIT]                = advert_ff.fast_half_duplex_advert;
		advert_word[`PIA_ADV_TEN_FD_BIT]                 = advert_ff.ten_full_duplex_advert;
		advert_word[`PIA_ADV_TEN_BIT]                    = advert_ff.ten_ability_advert;
		advert_word[`PIA_ADV_SEL_MSB:`PIA_ADV_SEL_LSB]   = advert_ff.selector;
		status_word                                      = `PIA_RST_WORD;
		status_word[`PIA_STAT_AN_DONE_BIT]               = AN_COMPLETE;
	end

	assign ADVERT = advert_ff;

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_comb begin
		case (REG_ADDR)
			`PIA_ADDR_BASIC_STATUS: begin
				nxt_rdata = status_word;
			end
			`PIA_ADDR_ID_HIGH: begin
				nxt_rdata = id_high_word;
			end
			`PIA_ADDR_ID_LOW: begin
				nxt_rdata = id_low_word;
			end
			`PIA_ADDR_ADVERT: begin
				nxt_rdata = advert_word;
			end
			default: begin
				nxt_rdata = `PIA_RST_WORD;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			rdata_ff <= `PIA_RST_WORD;
		end else if (REG_RD) begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= REG_RD;
		end
	end

	assign REG_RDATA  = rdata_ff;
	assign REG_RVALID = rvalid_ff;

	// ****************************************************************
	// Pause resolution
	// ****************************************************************
	assign local_pause = {advert_ff.pause_advert, advert_ff.asymmetric_pause_advert};

	pia_pause_resolve u_pause (
		.clk           (REF_CLK),
		.rst_n         (rst_sync_n_ff),
		.local_pause   (local_pause),
		.partner_pause (PARTNER_PAUSE),
		.an_complete   (AN_COMPLETE),
		.resolution_ff (PAUSE_RESOLVED)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!rst_sync_n_ff);

	id_high_read_a: assert property (REG_RD && REG_ADDR == `PIA_ADDR_ID_HIGH
		|=> REG_RVALID && REG_RDATA == (ID_ZERO ? `PIA_RST_WORD : ORG_ID[`PIA_ORG_HIGH_MSB:`PIA_ORG_HIGH_LSB]))
		else $error("High identifier read wrong");
	id_low_read_a: assert property (REG_RD && REG_ADDR == `PIA_ADDR_ID_LOW
		|=> REG_RDATA == (ID_ZERO ? `PIA_RST_WORD : {ORG_ID[`PIA_ORG_LOW_MSB:`PIA_ORG_LOW_LSB], MODEL, REV}))
		else $error("Low identifier read wrong");
	rsvd_zero_a: assert property (REG_RD && REG_ADDR == `PIA_ADDR_ADVERT
		|=> !REG_RDATA[`PIA_ADV_RSVD_HI_BIT] && !REG_RDATA[`PIA_ADV_RSVD_LO_BIT] && !REG_RDATA[`PIA_ADV_T4_BIT])
		else $error("Reserved advertisement bit read as one");

	// ****************************************************************
	// Advertisement checks
	// ****************************************************************
	next_page_wr_a: assert property (adv_write
		|=> ADVERT.next_page_request == $past(REG_WDATA[`PIA_ADV_NEXT_PAGE_BIT])
		&& ADVERT.selector == $past(REG_WDATA[`PIA_ADV_SEL_MSB:`PIA_ADV_SEL_LSB]))
		else $error("Advertisement write not stored");
	pause_wr_a: assert property (adv_write
		|=> {ADVERT.remote_fault_advert, ADVERT.asymmetric_pause_advert, ADVERT.pause_advert}
		== {$past(REG_WDATA[`PIA_ADV_REMOTE_FAULT_BIT]), $past(REG_WDATA[`PIA_ADV_ASYM_PAUSE_BIT]),
		$past(REG_WDATA[`PIA_ADV_PAUSE_BIT])})
		else $error("Fault or pause advertisement not stored");
	fast_wr_a: assert property (adv_write
		|=> {ADVERT.fast_full_duplex_advert, ADVERT.fast_half_duplex_advert, ADVERT.ten_full_duplex_advert,
		ADVERT.ten_ability_advert} == $past(REG_WDATA[`PIA_ADV_FAST_FD_BIT:`PIA_ADV_TEN_BIT]))
		else $error("Speed advertisement not stored");
	advert_hold_a: assert property (!adv_write && state_ff == pia_pkg::PIA_ST_RUN
		|=> $stable(ADVERT))
		else $error("Advertisement changed without a write");
	write_other_a: assert property (REG_WR && REG_ADDR != `PIA_ADDR_ADVERT && state_ff == pia_pkg::PIA_ST_RUN
		|=> $stable(ADVERT))
		else $error("Write to another register changed the advertisement");
	strap_load_a: assert property (state_ff == pia_pkg::PIA_ST_LOAD
		|=> {ADVERT.fast_full_duplex_advert, ADVERT.fast_half_duplex_advert,
		ADVERT.ten_full_duplex_advert, ADVERT.ten_ability_advert} == $past(STRAP)
		&& ADVERT.selector == `PIA_RST_SELECTOR && !ADVERT.next_page_request)
		else $error("Strap defaults not loaded");
	reset_vals_a: assert property (state_ff == pia_pkg::PIA_ST_LOAD
		|=> !ADVERT.remote_fault_advert && !ADVERT.asymmetric_pause_advert && !ADVERT.pause_advert)
		else $error("Fault or pause advertisement not reset");

	// ****************************************************************
	// Read port checks
	// ****************************************************************
	status_read_a: assert property (REG_RD && REG_ADDR == `PIA_ADDR_BASIC_STATUS
		|=> REG_RDATA == {10'h000, $past(AN_COMPLETE), 5'h00})
		else $error("Negotiation complete bit wrong");
	rdata_hold_a: assert property (!REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
		else $error("Read data moved without a read");
	rvalid_pulse_a: assert property (REG_RD |=> REG_RVALID)
		else $error("Read not answered in one cycle");
	adv_read_a: assert property (REG_RD && REG_ADDR == `PIA_ADDR_ADVERT
		|=> REG_RDATA[`PIA_ADV_NEXT_PAGE_BIT] == $past(ADVERT.next_page_request)
		&& REG_RDATA[`PIA_ADV_SEL_MSB:`PIA_ADV_SEL_LSB] == $past(ADVERT.selector))
		else $error("Advertisement read does not match stored fields");

	// ****************************************************************
	// Pause wiring checks
	// ****************************************************************
	pause_link_a: assert property (AN_COMPLETE && ADVERT.pause_advert && PARTNER_PAUSE.symmetric
		|=> PAUSE_RESOLVED == 2'h3)
		else $error("Symmetric pause not resolved at the port");
	asym_link_a: assert property (AN_COMPLETE && !ADVERT.pause_advert && ADVERT.asymmetric_pause_advert
		&& PARTNER_PAUSE.symmetric && PARTNER_PAUSE.asymmetric |=> PAUSE_RESOLVED == 2'h2)
		else $error("Transmit pause not resolved at the port");
	rx_link_a: assert property (AN_COMPLETE && ADVERT.pause_advert && ADVERT.asymmetric_pause_advert
		&& !PARTNER_PAUSE.symmetric && PARTNER_PAUSE.asymmetric |=> PAUSE_RESOLVED == 2'h1)
		else $error("Receive pause not resolved at the port");

	id_read_c: cover property (REG_RD && REG_ADDR == `PIA_ADDR_ID_LOW ##1 REG_RVALID);
	adv_wr_rd_c: cover property (adv_write ##1 REG_RD && REG_ADDR == `PIA_ADDR_ADVERT);
	an_done_c: cover property (REG_RD && REG_ADDR == `PIA_ADDR_BASIC_STATUS && AN_COMPLETE);
	rx_pause_c: cover property (AN_COMPLETE && PAUSE_RESOLVED == 2'h1);

endmodule // pia_regs_top

// ==== hw/pia_regs.svh ====
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

// ****************************************************************
// Register offsets on the management register port
// ****************************************************************
`define PIA_ADDR_BASIC_STATUS    5'h01
`define PIA_ADDR_ID_HIGH         5'h02
`define PIA_ADDR_ID_LOW          5'h03
`define PIA_ADDR_ADVERT          5'h04

// ****************************************************************
// Field positions
// ****************************************************************
`define PIA_ADV_NEXT_PAGE_BIT    15
`define PIA_ADV_RSVD_HI_BIT      14
`define PIA_ADV_REMOTE_FAULT_BIT 13
`define PIA_ADV_RSVD_LO_BIT      12
`define PIA_ADV_ASYM_PAUSE_BIT   11
`define PIA_ADV_PAUSE_BIT        10
`define PIA_ADV_T4_BIT           9
`define PIA_ADV_FAST_FD_BIT      8
`define PIA_ADV_FAST_HD_BIT      7
`define PIA_ADV_TEN_FD_BIT       6
`define PIA_ADV_TEN_BIT          5
`define PIA_ADV_SEL_MSB          4
`define PIA_ADV_SEL_LSB          0
`define PIA_STAT_AN_DONE_BIT     5
`define PIA_ORG_HIGH_MSB         21
`define PIA_ORG_HIGH_LSB         6
`define PIA_ORG_LOW_MSB          5
`define PIA_ORG_LOW_LSB          0

// ****************************************************************
// Reset values
// ****************************************************************
`define PIA_RST_BIT              1'h0
`define PIA_RST_SELECTOR         5'h01
`define PIA_RST_WORD             16'h0000
`define PIA_RST_PAUSE            2'h0

`endif

// ==== hw/pia_pkg.sv ====
package pia_pkg;

	typedef enum logic [0:0] {
		PIA_ST_LOAD = 1'b0,
		PIA_ST_RUN  = 1'b1
	} pia_state_type;

	typedef struct packed {
		logic       next_page_request;
		logic       remote_fault_advert;
		logic       asymmetric_pause_advert;
		logic       pause_advert;
		logic       fast_full_duplex_advert;
		logic       fast_half_duplex_advert;
		logic       ten_full_duplex_advert;
		logic       ten_ability_advert;
		logic [4:0] selector;
	} pia_advert_type;

	typedef struct packed {
		logic fast_full_duplex_advert;
		logic fast_half_duplex_advert;
		logic ten_full_duplex_advert;
		logic ten_ability_advert;
	} pia_strap_type;

	typedef struct packed {
		logic symmetric;
		logic asymmetric;
	} pia_pause_type;

endpackage

// ==== hw/pia_pause_resolve.sv ====
`timescale 1ns/100ps
`include "pia_regs.svh"

module pia_pause_resolve (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire pia_pkg::pia_pause_type local_pause,
	input  wire pia_pkg::pia_pause_type partner_pause,
	input  wire logic                   an_complete,
	output logic [1:0]                  resolution_ff
);

	logic tx_pause;
	logic rx_pause;
	logic [1:0] nxt_resolution;

	// ****************************************************************
	// Pause resolution, bit 1 transmit pause, bit 0 receive pause
	// ****************************************************************
	always_comb begin
		tx_pause = (local_pause.symmetric & partner_pause.symmetric) |
		           (local_pause.asymmetric & ~local_pause.symmetric &
		            partner_pause.symmetric & partner_pause.asymmetric);
		rx_pause = (local_pause.symmetric & partner_pause.symmetric) |
		           (local_pause.symmetric & local_pause.asymmetric &
		            ~partner_pause.symmetric & partner_pause.asymmetric);
		nxt_resolution = an_complete ? {tx_pause, rx_pause} : `PIA_RST_PAUSE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resolution_ff <= `PIA_RST_PAUSE;
		end else begin
			resolution_ff <= nxt_resolution;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sym_both_a: assert property (an_complete && local_pause.symmetric && partner_pause.symmetric
		|=> resolution_ff == 2'h3) else $error("Symmetric pause not resolved both ways");
	not_done_a: assert property (!an_complete |=> resolution_ff == 2'h0)
		else $error("Pause resolved before negotiation completed");
	asym_tx_a: assert property (an_complete && !local_pause.symmetric && local_pause.asymmetric
		&& partner_pause.symmetric && partner_pause.asymmetric |=> resolution_ff == 2'h2)
		else $error("Asymmetric transmit pause misresolved");

	sym_pause_c: cover property (an_complete && local_pause.symmetric && partner_pause.symmetric);

endmodule // pia_pause_resolve

// ==== tb/pia_mgmt_model.sv ====
`timescale 1ns/100ps

module pia_mgmt_model (
	input  wire logic  clk,
	output logic [4:0] reg_addr,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [15:0] reg_wdata
);
	// ****************************************************************
	// Station management requester
	// ****************************************************************
	initial begin
		reg_addr  = 5'h1f;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 16'hffff;
	end

	// Strobes drop to 0; address and write data show the inverse of their last value
	task automatic idle();
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_addr  = ~reg_addr;
		reg_wdata = ~reg_wdata;
		@(posedge clk);
		#10;
	endtask

	// One request, taken at the next edge; strobes held for back-to-back use
	task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data, input logic bad);
		logic [15:0] d;
		d = data;
		if (addr == 5'h04 && !bad) begin
			d[12] = 1'b0;
		end
		reg_rd   = ~wr;
		reg_wr   = wr;
		reg_addr = addr;
		if (wr) begin
			reg_wdata = d;
		end
		@(posedge clk);
		#10;
	endtask
endmodule // pia_mgmt_model

// ==== tb/pia_regs_top_test.sv ====
`timescale 1ns/100ps

module pia_regs_top_test;
	localparam logic [23:0] ORG   = 24'h3c5a69; // Arbitrary value
	localparam logic [5:0]  MODEL = 6'h2b;      // Arbitrary value
	localparam logic [3:0]  REV   = 4'h9;       // Arbitrary value

	logic                    ref_clk = 1'b0;
	logic                    rst_n;
	pia_pkg::pia_strap_type  strap;
	logic [4:0]              reg_addr;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [15:0]             reg_wdata;
	logic [15:0]             reg_rdata;
	logic                    reg_rvalid;
	logic                    an_complete;
	pia_pkg::pia_pause_type  partner_pause;
	pia_pkg::pia_advert_type advert;
	logic [1:0]              pause_resolved;
	logic [15:0]             exp_q[$];
	logic [15:0]             zero_rdata;
	logic [15:0]             exp_zero_q[$];
	int                      fail_count = 0;
	int                      samples_checked = 0;
	logic [15:0]             w;
	logic [4:0]              k;

	always #50 ref_clk = ~ref_clk;

	pia_regs_top #(.ORG_ID(ORG), .MODEL(MODEL), .REV(REV), .ID_ZERO(1'b0)) DUT (
		.REF_CLK(ref_clk), .RESET_N(rst_n), .STRAP(strap), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
		.AN_COMPLETE(an_complete), .PARTNER_PAUSE(partner_pause), .ADVERT(advert),
		.PAUSE_RESOLVED(pause_resolved));

	pia_regs_top #(.ORG_ID(ORG), .MODEL(MODEL), .REV(REV), .ID_ZERO(1'b1)) DUT_ZERO (
		.REF_CLK(ref_clk), .RESET_N(rst_n), .STRAP(strap), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(zero_rdata), .REG_RVALID(),
		.AN_COMPLETE(an_complete), .PARTNER_PAUSE(partner_pause), .ADVERT(),
		.PAUSE_RESOLVED());

	pia_mgmt_model mgmt (.clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));

	// ****************************************************************
	// Compare and verdict
	// ****************************************************************
	task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch REG_RDATA expected %h seen %h", e, g);
		end
	endtask

	task automatic cmp_advert(input pia_pkg::pia_advert_type e, input pia_pkg::pia_advert_type g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch ADVERT expected %h seen %h", e, g);
		end
	endtask

	task automatic cmp_pause(input logic [1:0] e, input logic [1:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch PAUSE_RESOLVED expected %h seen %h", e, g);
		end
	endtask

	task automatic stop_test();
		if (exp_q.size() != 0) begin
			fail_count++;
			$display("mismatch REG_RVALID expected %0d more seen 0", exp_q.size());
		end
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Local and partner given as {symmetric, asymmetric}; result {tx, rx}
	function automatic logic [1:0] pause_exp(input logic [1:0] l, input logic [1:0] p, input logic an);
		if (!an) return 2'h0;
		if (l[1] && p[1]) return 2'h3;
		if (l == 2'h1 && p == 2'h3) return 2'h2;
		if (l == 2'h3 && p == 2'h1) return 2'h1;
		return 2'h0;
	endfunction

	function automatic pia_pkg::pia_advert_type adv_of(input logic [15:0] d);
		return pia_pkg::pia_advert_type'({d[15], d[13], d[11:10], d[8:0]});
	endfunction

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		exp_zero_q.push_back((a == 5'h02 || a == 5'h03) ? 16'h0000 : e);
		mgmt.access(1'b0, a, 16'h0000, 1'b0);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask

	// ****************************************************************
	// Read result monitor
	// ****************************************************************
	always @(negedge ref_clk) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("mismatch REG_RVALID expected 0 seen 1");
			end else begin
				cmp_word(exp_q.pop_front(), reg_rdata);
				cmp_word(exp_zero_q.pop_front(), zero_rdata);
			end
		end
	end

	initial begin
		#1000000;
		fail_count++;
		stop_test();
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		rst_n         = 1'b0;
		an_complete   = 1'b0;
		partner_pause = 2'h0;
		strap         = 4'h0;
		void'($urandom(32'h35bc5a0a));
		for (int r = 0; r < 2; r++) begin
			rst_n       = 1'b0;
			an_complete = 1'b0;
			strap = pia_pkg::pia_strap_type'(4'($urandom));
			step(2);
			cmp_advert(13'h0001, advert);
			step(3);
			rst_n = 1'b1;
			step(6);
			rd(5'h02, ORG[21:6]);
			rd(5'h03, {ORG[5:0], MODEL, REV});
			rd(5'h04, {7'h00, strap, 5'h01});
			rd(5'h01, 16'h0000);
			rd(5'h1f, 16'h0000);
			for (int i = 0; i < 20; i++) begin
				w = 16'($urandom);
				if ($urandom_range(1) == 1) mgmt.idle();
				mgmt.access(1'b1, 5'h04, w, i[0]);
				cmp_advert(adv_of(w), advert);
				rd(5'h04, w & 16'hadff);
			end
			mgmt.access(1'b1, 5'h02, 16'($urandom), 1'b0);
			mgmt.access(1'b1, 5'h03, 16'($urandom), 1'b0);
			mgmt.access(1'b1, 5'h11, 16'($urandom), 1'b0);
			rd(5'h02, ORG[21:6]);
			rd(5'h03, {ORG[5:0], MODEL, REV});
			rd(5'h04, w & 16'hadff);
			for (int j = 0; j < 32; j++) begin
				k = 5'(j);
				w = 16'($urandom);
				w[10] = k[3];
				w[11] = k[2];
				partner_pause = pia_pkg::pia_pause_type'(k[1:0]);
				an_complete   = 1'b0;
				mgmt.access(1'b1, 5'h04, w, 1'b0);
				an_complete = k[4];
				mgmt.idle();
				mgmt.idle();
				cmp_pause(pause_exp({w[10], w[11]}, k[1:0], k[4]), pause_resolved);
				rd(5'h01, {10'h000, k[4], 5'h00});
			end
			mgmt.idle();
		end
		mgmt.idle();
		mgmt.idle();
		stop_test();
	end
endmodule // pia_regs_top_test
